//--- logic/ipfsf_regs.vh
`ifndef IPFSF_REGS_VH
`define IPFSF_REGS_VH

// ********************************************
// Register byte offsets
// ********************************************
`define IPFSF_OFF_CTRL      8'h00
`define IPFSF_OFF_SRC_ADDR  8'h04
`define IPFSF_OFF_SRC_MASK  8'h08
`define IPFSF_OFF_DST_ADDR  8'h0C
`define IPFSF_OFF_DST_MASK  8'h10
`define IPFSF_OFF_PROTO_NUM 8'h14
`define IPFSF_OFF_DSCP      8'h18
`define IPFSF_OFF_PASS_CNT  8'h1C
`define IPFSF_OFF_BLOCK_CNT 8'h20

// ********************************************
// Control register fields
// ********************************************
`define IPFSF_CTRL_SRC_EQ   0
`define IPFSF_CTRL_DST_EQ   1
`define IPFSF_CTRL_PROTO_EQ 2
`define IPFSF_CTRL_DSCP_EQ  3
`define IPFSF_CTRL_SEL_LO   4
`define IPFSF_CTRL_SEL_HI   5
`define IPFSF_CTRL_WIDTH    6

// ********************************************
// Protocol selection codes and numbers
// ********************************************
`define IPFSF_SEL_NUMERIC 2'h0
`define IPFSF_SEL_UDP     2'h1
`define IPFSF_SEL_TCP     2'h2
`define IPFSF_SEL_ICMP    2'h3
`define IPFSF_PROTO_UDP   8'h11
`define IPFSF_PROTO_TCP   8'h06
`define IPFSF_PROTO_ICMP  8'h01

// ********************************************
// Reset values
// ********************************************
`define IPFSF_RST_CTRL 6'h00
`define IPFSF_RST_WORD 32'h00000000
`define IPFSF_RST_BYTE 8'h00
`define IPFSF_RST_DSCP 6'h00

// ********************************************
// Frame byte positions (untagged Ethernet II)
// ********************************************
`define IPFSF_POS_TYPE_HI 6'h0C
`define IPFSF_POS_TYPE_LO 6'h0D
`define IPFSF_POS_VER     6'h0E
`define IPFSF_POS_TOS     6'h0F
`define IPFSF_POS_PROTO   6'h17
`define IPFSF_POS_SRC     6'h1A
`define IPFSF_POS_DST     6'h1E
`define IPFSF_POS_LAST    6'h21
`define IPFSF_POS_MAX     6'h3F
`define IPFSF_TYPE_HI     8'h08
`define IPFSF_TYPE_LO     8'h00
`define IPFSF_VERSION4    4'h4

// ********************************************
// AXI responses
// ********************************************
`define IPFSF_RESP_OKAY   2'h0
`define IPFSF_RESP_DECERR 2'h3

`endif

//--- logic/ipfsf_pair_buffer.v
// ********************************************
// Two-entry buffer, head always in entry 0
// ********************************************
module ipfsf_pair_buffer #(
	parameter WIDTH = 1
) (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	// Filling side
	input wire in_valid,
	input wire [WIDTH-1:0] in_data,
	output reg in_ready,
	// Draining side
	output reg out_valid,
	output reg [WIDTH-1:0] out_data,
	input wire out_ready
);

	reg [WIDTH-1:0] spare;
	reg [1:0] count;
	reg [1:0] next_count;
	wire push;
	wire pop;

	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always @*
	begin
		next_count = count;
		if (push && !pop)
			next_count = count + 2'h1;
		else if (pop && !push)
			next_count = count - 2'h1;
	end

	// Head stays in a flop so the output needs no mux
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			count <= 2'h0;
			in_ready <= 1'b1;
			out_valid <= 1'b0;
			out_data <= {WIDTH{1'b0}};
			spare <= {WIDTH{1'b0}};
		end
		else
		begin
			count <= next_count;
			in_ready <= (next_count != 2'h2);
			out_valid <= (next_count != 2'h0);
			if (pop)
			begin
				if (count == 2'h2)
					out_data <= spare;
				else if (push)
					out_data <= in_data;
			end
			else if (push && count == 2'h0)
				out_data <= in_data;
			if (push && (count == 2'h2 || (count == 2'h1 && !pop)))
				spare <= in_data;
		end
	end

endmodule // ipfsf_pair_buffer

//--- logic/ipfsf_filter.v
// Functional notes
// - Four IPv4 criteria; addresses have own masks.
// - Source criterion is Ignore or Equal-to.
// - Ignored source criterion blocks nothing by itself.
// - 32-bit source pattern compared under source mask.
// - Mask ANDed with both values before compare.
// - Destination criterion offers Ignore and Equal-to.
// - 32-bit destination pattern under separate mask.
// - Protocol criterion compares header protocol byte.
// - Protocol choice UDP=17, TCP=6, ICMP=1, Numeric.
// - Numeric number used only when Numeric selected.
// - DSCP criterion compares the 6-bit DSCP field.
// - DSCP Equal-to needs exact match with setting.
//
// The register offsets and register access over AXI4-Lite were decided locally.
`include "ipfsf_regs.vh"

module ipfsf_filter #(
	parameter CNT_WIDTH = 32
) (
	// Clock and reset
	input wire REF_CLK,
	input wire RSTN,
	// AXI4-Lite write address
	input wire AWVALID,
	output reg AWREADY,
	input wire [7:0] AWADDR,
	input wire [2:0] AWPROT,
	// AXI4-Lite write data
	input wire WVALID,
	output reg WREADY,
	input wire [31:0] WDATA,
	input wire [3:0] WSTRB,
	// AXI4-Lite write response
	output reg BVALID,
	input wire BREADY,
	output reg [1:0] BRESP,
	// AXI4-Lite read address
	input wire ARVALID,
	output reg ARREADY,
	input wire [7:0] ARADDR,
	input wire [2:0] ARPROT,
	// AXI4-Lite read data
	output reg RVALID,
	input wire RREADY,
	output reg [31:0] RDATA,
	output reg [1:0] RRESP,
	// Received frame bytes
	input wire S_VALID,
	output wire S_READY,
	input wire [7:0] S_DATA,
	input wire S_LAST,
	// Per-frame decision
	output wire D_VALID,
	output wire D_PASS,
	input wire D_READY
);

	// ********************************************
	// Address decode
	// ********************************************
	localparam IDX_CTRL = 4'h0;
	localparam IDX_SRC_ADDR = 4'h1;
	localparam IDX_SRC_MASK = 4'h2;
	localparam IDX_DST_ADDR = 4'h3;
	localparam IDX_DST_MASK = 4'h4;
	localparam IDX_PROTO_NUM = 4'h5;
	localparam IDX_DSCP = 4'h6;
	localparam IDX_PASS_CNT = 4'h7;
	localparam IDX_BLOCK_CNT = 4'h8;
	localparam IDX_NONE = 4'hF;

	function [3:0] reg_index;
		input [7:0] addr;
		begin
			case (addr)
				`IPFSF_OFF_CTRL: reg_index = IDX_CTRL;
				`IPFSF_OFF_SRC_ADDR: reg_index = IDX_SRC_ADDR;
				`IPFSF_OFF_SRC_MASK: reg_index = IDX_SRC_MASK;
				`IPFSF_OFF_DST_ADDR: reg_index = IDX_DST_ADDR;
				`IPFSF_OFF_DST_MASK: reg_index = IDX_DST_MASK;
				`IPFSF_OFF_PROTO_NUM: reg_index = IDX_PROTO_NUM;
				`IPFSF_OFF_DSCP: reg_index = IDX_DSCP;
				`IPFSF_OFF_PASS_CNT: reg_index = IDX_PASS_CNT;
				`IPFSF_OFF_BLOCK_CNT: reg_index = IDX_BLOCK_CNT;
				default: reg_index = IDX_NONE;
			endcase
		end
	endfunction

	// Byte-lane merge for partial writes
	function [31:0] merge;
		input [31:0] old;
		input [31:0] data;
		input [3:0] strb;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1)
				if (strb[i])
					merge[i*8 +: 8] = data[i*8 +: 8];
		end
	endfunction

	reg [`IPFSF_CTRL_WIDTH-1:0] ctrl;
	reg [31:0] src_addr, src_mask, dst_addr, dst_mask;
	reg [7:0] proto_num;
	reg [5:0] dscp_val;
	reg [CNT_WIDTH-1:0] pass_cnt, block_cnt;

	// ********************************************
	// Write channel
	// ********************************************
	reg aw_have, w_have;
	reg [7:0] aw_addr;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	wire [3:0] w_idx;
	wire do_write;

	assign w_idx = reg_index(aw_addr);
	assign do_write = aw_have && w_have && !BVALID;

	always @(posedge REF_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			AWREADY <= 1'b1;
			WREADY <= 1'b1;
			BVALID <= 1'b0;
			BRESP <= `IPFSF_RESP_OKAY;
			aw_have <= 1'b0;
			w_have <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end
		else
		begin
			// Address and data may arrive in either order
			if (AWVALID && AWREADY)
			begin
				aw_have <= 1'b1;
				aw_addr <= AWADDR;
				AWREADY <= 1'b0;
			end
			if (WVALID && WREADY)
			begin
				w_have <= 1'b1;
				w_data <= WDATA;
				w_strb <= WSTRB;
				WREADY <= 1'b0;
			end
			if (do_write)
			begin
				BVALID <= 1'b1;
				BRESP <= (w_idx == IDX_NONE) ? `IPFSF_RESP_DECERR : `IPFSF_RESP_OKAY;
			end
			if (BVALID && BREADY)
			begin
				BVALID <= 1'b0;
				aw_have <= 1'b0;
				w_have <= 1'b0;
				AWREADY <= 1'b1;
				WREADY <= 1'b1;
			end
		end
	end

	always @(posedge REF_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			ctrl <= `IPFSF_RST_CTRL;
			src_addr <= `IPFSF_RST_WORD;
			src_mask <= `IPFSF_RST_WORD;
			dst_addr <= `IPFSF_RST_WORD;
			dst_mask <= `IPFSF_RST_WORD;
			proto_num <= `IPFSF_RST_BYTE;
			dscp_val <= `IPFSF_RST_DSCP;
		end
		else if (do_write)
		begin
			case (w_idx)
				IDX_CTRL: ctrl <= w_strb[0] ? w_data[`IPFSF_CTRL_WIDTH-1:0] : ctrl;
				IDX_SRC_ADDR: src_addr <= merge(src_addr, w_data, w_strb);
				IDX_SRC_MASK: src_mask <= merge(src_mask, w_data, w_strb);
				IDX_DST_ADDR: dst_addr <= merge(dst_addr, w_data, w_strb);
				IDX_DST_MASK: dst_mask <= merge(dst_mask, w_data, w_strb);
				IDX_PROTO_NUM: proto_num <= w_strb[0] ? w_data[7:0] : proto_num;
				IDX_DSCP: dscp_val <= w_strb[0] ? w_data[5:0] : dscp_val;
				default: ctrl <= ctrl;
			endcase
		end
	end

	// ********************************************
	// Read channel
	// ********************************************
	reg [31:0] rd_word;
	wire [3:0] r_idx;

	assign r_idx = reg_index(ARADDR);

	always @*
	begin
		rd_word = 32'h00000000;
		case (r_idx)
			IDX_CTRL: rd_word[`IPFSF_CTRL_WIDTH-1:0] = ctrl;
			IDX_SRC_ADDR: rd_word = src_addr;
			IDX_SRC_MASK: rd_word = src_mask;
			IDX_DST_ADDR: rd_word = dst_addr;
			IDX_DST_MASK: rd_word = dst_mask;
			IDX_PROTO_NUM: rd_word[7:0] = proto_num;
			IDX_DSCP: rd_word[5:0] = dscp_val;
			IDX_PASS_CNT: rd_word[CNT_WIDTH-1:0] = pass_cnt;
			IDX_BLOCK_CNT: rd_word[CNT_WIDTH-1:0] = block_cnt;
			default: rd_word = 32'h00000000;
		endcase
	end

	always @(posedge REF_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			ARREADY <= 1'b1;
			RVALID <= 1'b0;
			RDATA <= 32'h00000000;
			RRESP <= `IPFSF_RESP_OKAY;
		end
		else if (ARVALID && ARREADY)
		begin
			ARREADY <= 1'b0;
			RVALID <= 1'b1;
			RDATA <= rd_word;
			RRESP <= (r_idx == IDX_NONE) ? `IPFSF_RESP_DECERR : `IPFSF_RESP_OKAY;
		end
		else if (RVALID && RREADY)
		begin
			RVALID <= 1'b0;
			ARREADY <= 1'b1;
		end
	end

	// ********************************************
	// Header capture
	// ********************************************
	reg [5:0] pos, f_dscp, next_dscp;
	reg type_ok, ver_ok, next_type_ok, next_ver_ok;
	reg [7:0] f_proto, next_proto;
	reg [31:0] f_src, f_dst, next_src, next_dst;
	wire beat, buf_ready;

	// Stall whole frame while the decision buffer is full
	assign beat = S_VALID && buf_ready;
	assign S_READY = buf_ready;

	always @*
	begin
		next_type_ok = type_ok;
		next_ver_ok = ver_ok;
		next_dscp = f_dscp;
		next_proto = f_proto;
		next_src = f_src;
		next_dst = f_dst;
		if (pos == `IPFSF_POS_TYPE_HI)
			next_type_ok = (S_DATA == `IPFSF_TYPE_HI);
		if (pos == `IPFSF_POS_TYPE_LO)
			next_type_ok = type_ok && (S_DATA == `IPFSF_TYPE_LO);
		if (pos == `IPFSF_POS_VER)
			next_ver_ok = (S_DATA[7:4] == `IPFSF_VERSION4);
		if (pos == `IPFSF_POS_TOS)
			next_dscp = S_DATA[7:2];
		if (pos == `IPFSF_POS_PROTO)
			next_proto = S_DATA;
		if (pos >= `IPFSF_POS_SRC && pos < `IPFSF_POS_DST)
			next_src = {f_src[23:0], S_DATA};
		if (pos >= `IPFSF_POS_DST && pos <= `IPFSF_POS_LAST)
			next_dst = {f_dst[23:0], S_DATA};
	end

	always @(posedge REF_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			pos <= 6'h00;
			type_ok <= 1'b0;
			ver_ok <= 1'b0;
			f_dscp <= 6'h00;
			f_proto <= 8'h00;
			f_src <= 32'h00000000;
			f_dst <= 32'h00000000;
		end
		else if (beat)
		begin
			type_ok <= next_type_ok;
			ver_ok <= next_ver_ok;
			f_dscp <= next_dscp;
			f_proto <= next_proto;
			f_src <= next_src;
			f_dst <= next_dst;
			if (S_LAST)
				pos <= 6'h00;
			else if (pos != `IPFSF_POS_MAX)
				pos <= pos + 6'h01;
		end
	end

	// ********************************************
	// Decision
	// ********************************************
	reg [7:0] want_proto;
	wire is_ipv4, src_ok, dst_ok, proto_ok, dscp_ok, pass, push;

	always @*
	begin
		case (ctrl[`IPFSF_CTRL_SEL_HI:`IPFSF_CTRL_SEL_LO])
			`IPFSF_SEL_UDP: want_proto = `IPFSF_PROTO_UDP;
			`IPFSF_SEL_TCP: want_proto = `IPFSF_PROTO_TCP;
			`IPFSF_SEL_ICMP: want_proto = `IPFSF_PROTO_ICMP;
			default: want_proto = proto_num;
		endcase
	end

	// A frame too short to carry the whole header is not IPv4
	assign is_ipv4 = next_type_ok && next_ver_ok && (pos >= `IPFSF_POS_LAST);
	// Ignored criterion is true so it blocks nothing
	assign src_ok = !ctrl[`IPFSF_CTRL_SRC_EQ] ||
		((next_src & src_mask) == (src_addr & src_mask));
	assign dst_ok = !ctrl[`IPFSF_CTRL_DST_EQ] ||
		((next_dst & dst_mask) == (dst_addr & dst_mask));
	assign proto_ok = !ctrl[`IPFSF_CTRL_PROTO_EQ] || (next_proto == want_proto);
	assign dscp_ok = !ctrl[`IPFSF_CTRL_DSCP_EQ] || (next_dscp == dscp_val);
	assign pass = is_ipv4 && src_ok && dst_ok && proto_ok && dscp_ok;
	assign push = beat && S_LAST;

	always @(posedge REF_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			pass_cnt <= {CNT_WIDTH{1'b0}};
			block_cnt <= {CNT_WIDTH{1'b0}};
		end
		else if (push)
		begin
			if (pass)
				pass_cnt <= pass_cnt + {{(CNT_WIDTH-1){1'b0}}, 1'b1};
			else
				block_cnt <= block_cnt + {{(CNT_WIDTH-1){1'b0}}, 1'b1};
		end
	end

	// Two decisions buffered so a slow reader loses none
	ipfsf_pair_buffer #(
		.WIDTH(1)
	) u_buffer (
		.clk(REF_CLK),
		.rst_n(RSTN),
		.in_valid(push),
		.in_data(pass),
		.in_ready(buf_ready),
		.out_valid(D_VALID),
		.out_data(D_PASS),
		.out_ready(D_READY)
	);

endmodule // ipfsf_filter

//--- verification/ipfsf_properties.sv
module ipfsf_properties (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic RSTN,
	// Register bus
	input wire logic AWVALID,
	input wire logic AWREADY,
	input wire logic WVALID,
	input wire logic WREADY,
	input wire logic BVALID,
	input wire logic BREADY,
	input wire logic [1:0] BRESP,
	input wire logic ARVALID,
	input wire logic ARREADY,
	input wire logic [7:0] ARADDR,
	input wire logic RVALID,
	input wire logic RREADY,
	input wire logic [31:0] RDATA,
	input wire logic [1:0] RRESP,
	// Frames and decisions
	input wire logic S_VALID,
	input wire logic S_READY,
	input wire logic S_LAST,
	input wire logic D_VALID,
	input wire logic D_PASS,
	input wire logic D_READY
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****
	// Checks
	// ****
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RSTN);
	a_write_answer: assert property (AWVALID && AWREADY && WVALID && WREADY |=> !AWREADY && !WREADY ##1 BVALID)
		else $error("write not answered");
	a_write_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
		else $error("write response dropped");
	a_read_answer: assert property (ARVALID && ARREADY |=> RVALID && !ARREADY)
		else $error("read not answered");
	a_read_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA) && $stable(RRESP))
		else $error("read data dropped");
	a_read_decerr: assert property (ARVALID && ARREADY && (ARADDR > 8'h20 || ARADDR[1:0] != 2'h0)
		|=> RRESP == 2'h3 && RDATA == 32'h0)
		else $error("unmapped read accepted");
	a_read_okay: assert property (ARVALID && ARREADY && ARADDR <= 8'h20 && ARADDR[1:0] == 2'h0 |=> RRESP == 2'h0)
		else $error("mapped read refused");
	a_decision_due: assert property (S_VALID && S_READY && S_LAST |=> D_VALID)
		else $error("decision late");
	a_decision_hold: assert property (D_VALID && !D_READY |=> D_VALID && $stable(D_PASS))
		else $error("decision dropped");
	a_stall_cause: assert property (!S_READY |-> D_VALID)
		else $error("stall without pending decision");
endmodule // ipfsf_properties

bind ipfsf_filter ipfsf_properties u_props (.*);

//--- verification/ipfsf_frame_src.sv
module ipfsf_frame_src (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Frame request
	input wire logic go,
	input wire logic slow,
	input wire logic [271:0] bytes,
	input wire logic [5:0] last_idx,
	output logic busy,
	// Byte stream
	output logic s_valid,
	output logic [7:0] s_data,
	output logic s_last,
	input wire logic s_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0] idx;
	logic [5:0] n;
	logic done;
	// Next byte index, and end of frame taken
	assign n = s_valid ? idx + 6'h01 : idx;
	assign done = s_valid && s_last;
	// ****
	// Byte source, held until taken
	// ****
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			busy <= 1'b0;
			idx <= 6'h00;
			s_valid <= 1'b0;
			s_data <= 8'h00;
			s_last <= 1'b0;
		end
		else if (go)
		begin
			busy <= 1'b1;
			idx <= 6'h00;
		end
		else if (!(s_valid && !s_ready))
		begin
			idx <= n;
			if (done)
				busy <= 1'b0;
			if (busy && !done && (!slow || $urandom_range(1)))
			begin
				s_valid <= 1'b1;
				s_data <= bytes[8*n +: 8];
				s_last <= (n == last_idx);
			end
			else
			begin
				// Idle line toggles so stale bytes never look valid
				s_valid <= 1'b0;
				s_data <= ~s_data;
				s_last <= 1'b0;
			end
		end
	end
endmodule // ipfsf_frame_src

//--- verification/ipfsf_filter_tb.sv
module ipfsf_filter_tb;
	timeunit 1ns;
	timeprecision 1ps;
`include "ipfsf_regs.vh"
	logic REF_CLK = 1'b0, RSTN = 1'b0, AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0;
	logic ARVALID = 1'b0, RREADY = 1'b0, D_READY = 1'b0, go = 1'b0, slow = 1'b0;
	logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00, S_DATA, pn;
	logic [2:0] AWPROT = 3'h0, ARPROT = 3'h0;
	logic [31:0] WDATA = 32'h0, RDATA, sp, sm, dp, dm, npass, nblock;
	logic [3:0] WSTRB = 4'hF;
	logic AWREADY, WREADY, BVALID, ARREADY, RVALID, S_VALID, S_READY, S_LAST, D_VALID, D_PASS, busy;
	logic [1:0] BRESP, RRESP;
	logic [271:0] fb = '0;
	logic [5:0] last_idx = 6'h21, ctrl, dv;
	logic [33:0] rq[$];
	logic dq[$];
	logic [1:0] bq[$];
	int fails = 0, n_compared = 0;
	always #2 REF_CLK = ~REF_CLK;
	ipfsf_filter uut (.*);
	ipfsf_frame_src u_src (.clk(REF_CLK), .rst_n(RSTN), .go(go), .slow(slow), .bytes(fb), .last_idx(last_idx),
		.busy(busy), .s_valid(S_VALID), .s_data(S_DATA), .s_last(S_LAST), .s_ready(S_READY));
	// ****
	// Checking and bus tasks
	// ****
	task check(input logic [33:0] seen, input logic [33:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			fails++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	always @(posedge REF_CLK)
	begin
		// Random stalls delay reading decisions from the buffer
		D_READY <= $urandom_range(1);
		if (RVALID && RREADY)
			check({RRESP, RDATA}, rq.pop_front());
		if (BVALID && BREADY)
			check({32'h0, BRESP}, {32'h0, bq.pop_front()});
		if (D_VALID && D_READY)
			check({33'h0, D_PASS}, {33'h0, dq.pop_front()});
	end
	task wr(input logic [7:0] a, input logic [31:0] d);
		bq.push_back((a > `IPFSF_OFF_BLOCK_CNT || a[1:0] != 2'h0) ? `IPFSF_RESP_DECERR : `IPFSF_RESP_OKAY);
		@(posedge REF_CLK);
		AWVALID <= 1'b1;
		AWADDR <= a;
		WVALID <= 1'b1;
		WDATA <= d;
		BREADY <= 1'b1;
		do
		begin
			@(posedge REF_CLK);
			if (AWREADY)
				AWVALID <= 1'b0;
			if (WREADY)
				WVALID <= 1'b0;
		end
		while (!BVALID);
		BREADY <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [33:0] exp);
		rq.push_back(exp);
		@(posedge REF_CLK);
		ARVALID <= 1'b1;
		ARADDR <= a;
		RREADY <= 1'b1;
		do
		begin
			@(posedge REF_CLK);
			if (ARREADY)
				ARVALID <= 1'b0;
		end
		while (!RVALID);
		RREADY <= 1'b0;
	endtask
	task config_all(input logic [1:0] sel);
		ctrl = {sel, 4'($urandom)};
		sp = $urandom;
		sm = $urandom;
		dp = $urandom;
		dm = $urandom;
		pn = 8'($urandom);
		dv = 6'($urandom);
		wr(`IPFSF_OFF_CTRL, {26'h0, ctrl});
		wr(`IPFSF_OFF_SRC_ADDR, sp);
		wr(`IPFSF_OFF_SRC_MASK, sm);
		wr(`IPFSF_OFF_DST_ADDR, dp);
		wr(`IPFSF_OFF_DST_MASK, dm);
		wr(`IPFSF_OFF_PROTO_NUM, {24'h0, pn});
		wr(`IPFSF_OFF_DSCP, {26'h0, dv});
		rd(`IPFSF_OFF_CTRL, {28'h0, ctrl});
		rd(`IPFSF_OFF_SRC_ADDR, {2'h0, sp});
		rd(`IPFSF_OFF_DST_MASK, {2'h0, dm});
		rd(`IPFSF_OFF_PROTO_NUM, {26'h0, pn});
		rd(`IPFSF_OFF_DSCP, {28'h0, dv});
	endtask
	task send(input logic v4, input logic short_f);
		logic [31:0] s, d;
		logic [7:0] p, pv;
		logic [5:0] q;
		logic ok;
		// Near-misses: only a few bits differ from the pattern
		s = sp ^ ($urandom & $urandom & $urandom);
		d = dp ^ ($urandom & $urandom & $urandom);
		case (ctrl[5:4])
			2'h1: pv = 8'h11;
			2'h2: pv = 8'h06;
			2'h3: pv = 8'h01;
			default: pv = pn;
		endcase
		p = $urandom_range(1) ? pv : 8'($urandom);
		q = $urandom_range(1) ? dv : 6'($urandom);
		for (int k = 0; k < 34; k++)
			fb[8*k +: 8] = 8'($urandom);
		fb[96 +: 16] = v4 ? 16'h0008 : 16'hDD86;
		fb[112 +: 16] = {q, 2'h2, 8'h45};
		fb[184 +: 8] = p;
		for (int k = 0; k < 4; k++)
		begin
			fb[8*(26+k) +: 8] = s[31-8*k -: 8];
			fb[8*(30+k) +: 8] = d[31-8*k -: 8];
		end
		last_idx = short_f ? 6'h1D : 6'h21;
		ok = v4 && !short_f && (!ctrl[0] || (s & sm) == (sp & sm)) && (!ctrl[1] || (d & dm) == (dp & dm))
			&& (!ctrl[2] || p == pv) && (!ctrl[3] || q == dv);
		dq.push_back(ok);
		if (ok)
			npass++;
		else
			nblock++;
		@(posedge REF_CLK);
		go <= 1'b1;
		@(posedge REF_CLK);
		go <= 1'b0;
		do @(negedge REF_CLK); while (busy);
	endtask
	task tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ****
	// Main sequence and watchdog
	// ****
	initial
	begin
		void'($urandom(44596));
		npass = 0;
		nblock = 0;
		repeat (10) @(posedge REF_CLK);
		RSTN <= 1'b1;
		for (int a = 0; a <= 36; a += 4)
			rd(8'(a), {(a == 36) ? 2'h3 : 2'h0, 32'h0});
		$display("test reset values done");
		// Byte lanes 0 and 2 only, then a read-only and an unmapped write
		WSTRB <= 4'h5;
		wr(`IPFSF_OFF_SRC_MASK, 32'hFFFFFFFF);
		WSTRB <= 4'hF;
		wr(`IPFSF_OFF_PASS_CNT, 32'hFFFFFFFF);
		wr(8'h24, 32'hFFFFFFFF);
		rd(`IPFSF_OFF_SRC_MASK, {2'h0, 32'h00FF00FF});
		rd(`IPFSF_OFF_PASS_CNT, {2'h0, 32'h0});
		$display("test write strobes done");
		for (int i = 0; i < 64; i++)
		begin
			if (i % 4 == 0)
				config_all(2'(i / 4));
			slow = i[0];
			send($urandom_range(7) != 0, $urandom_range(7) == 0);
		end
		while (dq.size() != 0)
			@(posedge REF_CLK);
		$display("test random filtering done");
		rd(`IPFSF_OFF_PASS_CNT, {2'h0, npass});
		rd(`IPFSF_OFF_BLOCK_CNT, {2'h0, nblock});
		$display("test counters done");
		tally_and_finish;
	end
	initial
	begin
		repeat (30000) @(posedge REF_CLK);
		fails++;
		tally_and_finish;
	end
endmodule // ipfsf_filter_tb
